/* File: dv/aac_host.sv */
// Host model issuing APB transfers to the converter register slice
`timescale 1ns/1ps
module aac_host (
  // Clock
  input wire logic clk_in,
  // Slave answer
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  // Request and timeout flag
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out,
  output logic tmo_out
);
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
    pstrb_out = 4'hf;
    tmo_out = 1'b0;
  end
  // Request held until pready is seen at an edge; bounded so a hang ends
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_in !== 1'b1 && n < 16);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    if (pready_in !== 1'b1) tmo_out = 1'b1;
  endtask : xfer
  // Lanes hold until changed; call only right after a clock edge
  task automatic set_lanes(input logic [3:0] s);
    pstrb_out <= s;
  endtask : set_lanes
endmodule : aac_host

/* File: dv/tb_top.sv */
// Self-checking bench for the converter correction and step-0 slice
`timescale 1ns/1ps
module tb_top;
  logic REF_CLK_IN = 1'b0;
  logic SRST_IN = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  aac_pkg::aac_sample_type smp = '0;
  aac_pkg::aac_result_type res;
  aac_pkg::aac_mux_type mux;
  int err_total = 0;
  int checks = 0;
  always #5 REF_CLK_IN = ~REF_CLK_IN;
  aac_regs aac_regs_inst (.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SAMPLE_IN(smp), .RESULT_OUT(res), .MUX_OUT(mux));
  aac_host aac_host_inst (.clk_in(REF_CLK_IN), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb), .tmo_out());
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    aac_host_inst.xfer(w, a, d, r, e);
    if (aac_host_inst.tmo_out)
    begin
      err_total++;
      final_report();
    end
  endtask : acc
  // Reset values, write/read back, unmapped place
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    acc(1'b0, aac_pkg::ADDR_STEP0_CFG, 32'h0, r, e);
    chk(r, 32'h0);
    chk({mux.step_en, mux.gain_onehot, mux.ext_onehot, mux.neg_gnd}, 32'h203);
    acc(1'b0, aac_pkg::ADDR_OFFSET_CORR, 32'h0, r, e);
    chk(r, {16'h0, aac_pkg::RST_OFFSET_CORR});
    acc(1'b0, aac_pkg::ADDR_GAIN_CORR, 32'h0, r, e);
    chk(r, 32'h0);
    acc(1'b1, aac_pkg::ADDR_OFFSET_CORR, 32'hffff_8001, r, e);
    acc(1'b0, aac_pkg::ADDR_OFFSET_CORR, 32'h0, r, e);
    chk(r, 32'h8001);
    aac_host_inst.set_lanes(4'h1);
    acc(1'b1, aac_pkg::ADDR_OFFSET_CORR, 32'h0000_12ab, r, e);
    aac_host_inst.set_lanes(4'hf);
    acc(1'b0, aac_pkg::ADDR_OFFSET_CORR, 32'h0, r, e);
    chk(r, 32'h80ab);
    acc(1'b1, aac_pkg::ADDR_GAIN_CORR, 32'h0000_8000, r, e);
    acc(1'b0, aac_pkg::ADDR_GAIN_CORR, 32'h0, r, e);
    chk(r, 32'h8000);
    acc(1'b1, 12'h244, 32'h1234, r, e);
    chk({31'h0, e}, 32'h1);
    acc(1'b0, 12'h244, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask : t_regs
  // Every field code of the step word against the multiplexer controls
  task automatic t_mux();
    logic [31:0] r;
    logic e;
    logic [3:0] p;
    logic [1:0] g;
    logic n, en;
    for (int i = 0; i < 256; i++)
    begin
      {g, en, n, p} = i[7:0];
      acc(1'b1, aac_pkg::ADDR_STEP0_CFG, {16'h0, en, g, 8'hff, n, p}, r, e);
      acc(1'b0, aac_pkg::ADDR_STEP0_CFG, 32'h0, r, e);
      chk(r, {16'h0, en, g, 8'h00, n, p});
      chk({mux.step_en, mux.gain_onehot}, {en, g[1], g == 2'h1, g == 2'h0});
      chk(mux.ext_onehot, p[3] ? 8'h00 : 8'h01 << p[2:0]);
      chk(mux.int_onehot, p[3] ? 8'h01 << p[2:0] : 8'h00);
      chk(mux.neg_auto, p[3]);
      chk(mux.pos_code, p);
      if (!p[3])
        chk({mux.neg_ext7, mux.neg_gnd}, {n, !n});
    end
  endtask : t_mux
  // Reference arithmetic: {clip, data}
  function automatic logic [31:0] model(input logic [15:0] oc, input logic [15:0] gc,
    input logic [1:0] g, input logic [15:0] d);
    longint s;
    s = longint'($signed(oc));
    if (g != 2'h0) s = s >>> 1;
    s = (s + longint'($signed(d))) * (65536 + longint'($signed(gc))) >>> 16;
    if (s > 32767) return 32'h1_7fff;
    if (s < -32768) return 32'h1_8000;
    return {16'h0, s[15:0]};
  endfunction : model
  // Offset step per gain, gain word extremes, saturation
  task automatic t_math();
    logic [31:0] r, x;
    logic e;
    logic [15:0] oc [6] = '{16'h0010, 16'h0011, 16'h0, 16'h0, 16'h7fff, 16'h0002};
    logic [15:0] gc [6] = '{16'h0, 16'h0, 16'h7fff, 16'h8000, 16'h0, 16'h0};
    logic [1:0] gn [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h2};
    logic [15:0] dt [6] = '{16'h0064, 16'h0064, 16'h03e8, 16'hfc18, 16'h7fff, 16'h0100};
    for (int k = 0; k < 6; k++)
    begin
      acc(1'b1, aac_pkg::ADDR_OFFSET_CORR, {16'h0, oc[k]}, r, e);
      acc(1'b1, aac_pkg::ADDR_GAIN_CORR, {16'h0, gc[k]}, r, e);
      acc(1'b1, aac_pkg::ADDR_STEP0_CFG, {17'h0, gn[k], 13'h0}, r, e);
      smp <= '{valid: 1'b1, data: dt[k]};
      @(posedge REF_CLK_IN);
      smp.valid <= 1'b0;
      x = model(oc[k], gc[k], gn[k], dt[k]);
      #1;
      chk({res.valid, res.clip, res.data}, {1'b1, x[16:0]});
      @(posedge REF_CLK_IN);
      #1;
      chk(res.valid, 1'b0);
    end
  endtask : t_math
  // Reset in mid-run clears every word and the multiplexer controls
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    acc(1'b1, aac_pkg::ADDR_STEP0_CFG, 32'h0000_e01b, r, e);
    SRST_IN <= 1'b1;
    repeat (2) @(posedge REF_CLK_IN);
    SRST_IN <= 1'b0;
    acc(1'b0, aac_pkg::ADDR_OFFSET_CORR, 32'h0, r, e);
    chk(r, {16'h0, aac_pkg::RST_OFFSET_CORR});
    acc(1'b0, aac_pkg::ADDR_GAIN_CORR, 32'h0, r, e);
    chk(r, {16'h0, aac_pkg::RST_GAIN_CORR});
    acc(1'b0, aac_pkg::ADDR_STEP0_CFG, 32'h0, r, e);
    chk(r, {16'h0, aac_pkg::RST_STEP0_CFG});
    chk({mux.step_en, mux.gain_onehot, mux.ext_onehot, mux.neg_gnd}, 32'h203);
  endtask : t_reset
  initial
  begin
    repeat (3) @(posedge REF_CLK_IN);
    SRST_IN <= 1'b0;
    t_regs();
    t_mux();
    t_math();
    t_reset();
    final_report();
  end
endmodule : tb_top

/* File: logic/aac_pkg.sv */
// Package: register map, field layout and carrier types of the aux converter slice
package aac_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OFFSET_CORR = 8'h8e;
  localparam logic [7:0] IDX_GAIN_CORR = 8'h8f;
  localparam logic [7:0] IDX_STEP0_CFG = 8'h90;
  localparam logic [11:0] ADDR_OFFSET_CORR = {2'h0, IDX_OFFSET_CORR, 2'h0};
  localparam logic [11:0] ADDR_GAIN_CORR = {2'h0, IDX_GAIN_CORR, 2'h0};
  localparam logic [11:0] ADDR_STEP0_CFG = {2'h0, IDX_STEP0_CFG, 2'h0};

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_OFFSET_CORR = 16'h0000;
  localparam logic [15:0] RST_GAIN_CORR = 16'h0000;
  localparam logic [15:0] RST_STEP0_CFG = 16'h0000;
  localparam int STEP_EN_POS = 15;
  localparam int STEP_GAIN_HI = 14;
  localparam int STEP_GAIN_LO = 13;
  localparam int STEP_NEG_POS = 4;
  localparam int STEP_POS_HI = 3;
  localparam int STEP_POS_LO = 0;

  // ----------------------------------------------------------------
  // Encodings and arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
  localparam logic [3:0] POS_INT_SHORT = 4'h9;
  localparam logic signed [17:0] GAIN_UNITY = 18'sh10000;
  localparam int RESULT_LATENCY = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } aac_sample_type;

  typedef struct packed {
    logic valid;
    logic clip;
    logic signed [15:0] data;
  } aac_result_type;

  typedef struct packed {
    logic step_en;
    logic [2:0] gain_onehot;
    logic [3:0] pos_code;
    logic [7:0] ext_onehot;
    logic [7:0] int_onehot;
    logic neg_gnd;
    logic neg_ext7;
    logic neg_auto;
  } aac_mux_type;

  typedef struct packed {
    logic [15:0] ocal;
    logic [15:0] gcal;
    logic step_en;
    logic [1:0] gain;
    logic neg_sel;
    logic [3:0] pos_sel;
    logic [31:0] rdata;
    logic slverr;
    aac_result_type result;
  } aac_state_type;

endpackage : aac_pkg

/* File: logic/aac_regs.sv */
// Module: aux converter correction words, step-0 config and sample correction
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Signed 16-bit offset word, read/write, added to each conversion result.
// RULE2 - At gain one an offset step equals one result step.
// RULE3 - At gain two or four an offset step is half a result step.
// RULE4 - Gain word signed, factor is one plus code over 65536.
// RULE5 - Bit 15 includes step 0 in the sequence; resets disabled.
// RULE6 - Bits 14:13 pick gain: 00 one, 01 two, 10 and 11 four.
// RULE7 - Bit 4 picks negative input: 0 analog ground, 1 external input seven.
// RULE8 - Positive codes 0000 to 0111 pick external inputs zero to seven.
// RULE9 - Codes 1000 upward pick the negative input automatically, ignoring bit 4.
// RULE10 - Code 1000 routes temperature sensor; 1001 shorts input to analog ground.
// RULE11 - Codes 1010 to 1111 route test output and scaled supply monitors.
// RULE12 - Bits 12 to 5 ignore writes and read as zero.
module aac_regs (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Conversion path
  input wire aac_pkg::aac_sample_type SAMPLE_IN,
  output aac_pkg::aac_result_type RESULT_OUT,
  // Multiplexer control for step 0
  output aac_pkg::aac_mux_type MUX_OUT
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] gain_onehot(input logic [1:0] code);
    logic [2:0] g;
    g = 3'h4;
    if (code == aac_pkg::GAIN_CODE_X1)
    begin
      g = 3'h1;
    end
    else if (code == aac_pkg::GAIN_CODE_X2)
    begin
      g = 3'h2;
    end
    return g;
  endfunction : gain_onehot

  function automatic logic [16:0] sat16(input logic signed [19:0] v);
    logic [16:0] r;
    r = {1'b0, v[15:0]};
    if (v > 20'sh07fff)
    begin
      r = {1'b1, 16'h7fff};
    end
    else if (v < -20'sh08000)
    begin
      r = {1'b1, 16'h8000};
    end
    return r;
  endfunction : sat16

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0])
    begin
      m[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction : merge16

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aac_pkg::aac_state_type st_r;
  aac_pkg::aac_state_type st_nxt;
  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  logic [15:0] step_word;
  logic [15:0] step_wr;
  logic signed [17:0] offset_eff;
  logic signed [17:0] sum_corr;
  logic signed [17:0] gain_factor;
  logic signed [35:0] product;
  logic [16:0] sat_res;

  assign setup_phase = PSEL_IN && !PENABLE_IN;
  assign access_phase = PSEL_IN && PENABLE_IN;
  assign addr_hit = (PADDR_IN == aac_pkg::ADDR_OFFSET_CORR) ||
                    (PADDR_IN == aac_pkg::ADDR_GAIN_CORR) ||
                    (PADDR_IN == aac_pkg::ADDR_STEP0_CFG);
  // Reserved middle bits are never stored, so they always read zero
  assign step_word = {st_r.step_en, st_r.gain, 8'h00, st_r.neg_sel, st_r.pos_sel}; // [RULE12]
  assign step_wr = merge16(step_word, PWDATA_IN, PSTRB_IN);

  // ----------------------------------------------------------------
  // Correction arithmetic
  // ----------------------------------------------------------------
  // Half-step offset at higher gain drops the word's lowest bit (floor)
  always_comb
  begin
    if (st_r.gain == aac_pkg::GAIN_CODE_X1)
    begin
      offset_eff = {{2{st_r.ocal[15]}}, st_r.ocal}; // [RULE2]
    end
    else
    begin
      offset_eff = {{3{st_r.ocal[15]}}, st_r.ocal[15:1]}; // [RULE3]
    end
  end

  assign sum_corr = {{2{SAMPLE_IN.data[15]}}, SAMPLE_IN.data} + offset_eff; // [RULE1]
  assign gain_factor = aac_pkg::GAIN_UNITY + {{2{st_r.gcal[15]}}, st_r.gcal}; // [RULE4]
  assign product = sum_corr * gain_factor; // [RULE4]
  assign sat_res = sat16(product[35:16]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.result.valid = 1'b0;
    if (setup_phase)
    begin
      st_nxt.slverr = !addr_hit;
      st_nxt.rdata = 32'h0000_0000;
      if (PADDR_IN == aac_pkg::ADDR_OFFSET_CORR)
      begin
        st_nxt.rdata = {16'h0000, st_r.ocal};
      end
      else if (PADDR_IN == aac_pkg::ADDR_GAIN_CORR)
      begin
        st_nxt.rdata = {16'h0000, st_r.gcal};
      end
      else if (PADDR_IN == aac_pkg::ADDR_STEP0_CFG)
      begin
        st_nxt.rdata = {16'h0000, step_word}; // [RULE12]
      end
    end
    if (access_phase && PWRITE_IN)
    begin
      if (PADDR_IN == aac_pkg::ADDR_OFFSET_CORR)
      begin
        st_nxt.ocal = merge16(st_r.ocal, PWDATA_IN, PSTRB_IN); // [RULE1]
      end
      else if (PADDR_IN == aac_pkg::ADDR_GAIN_CORR)
      begin
        st_nxt.gcal = merge16(st_r.gcal, PWDATA_IN, PSTRB_IN); // [RULE4]
      end
      else if (PADDR_IN == aac_pkg::ADDR_STEP0_CFG)
      begin
        st_nxt.step_en = step_wr[aac_pkg::STEP_EN_POS]; // [RULE5]
        st_nxt.gain = step_wr[aac_pkg::STEP_GAIN_HI:aac_pkg::STEP_GAIN_LO]; // [RULE6]
        st_nxt.neg_sel = step_wr[aac_pkg::STEP_NEG_POS]; // [RULE7]
        st_nxt.pos_sel = step_wr[aac_pkg::STEP_POS_HI:aac_pkg::STEP_POS_LO]; // [RULE8]
      end
    end
    if (SAMPLE_IN.valid)
    begin
      st_nxt.result.valid = 1'b1;
      st_nxt.result.clip = sat_res[16];
      st_nxt.result.data = sat_res[15:0];
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      st_r <= '{ocal: aac_pkg::RST_OFFSET_CORR, gcal: aac_pkg::RST_GAIN_CORR,
                 step_en: aac_pkg::RST_STEP0_CFG[15], gain: aac_pkg::RST_STEP0_CFG[14:13],
                 neg_sel: aac_pkg::RST_STEP0_CFG[4], pos_sel: aac_pkg::RST_STEP0_CFG[3:0],
                 rdata: 32'h0000_0000, slverr: 1'b0, result: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave: read data is captured in the setup cycle
  assign PREADY_OUT = access_phase;
  assign PRDATA_OUT = st_r.rdata;
  assign PSLVERR_OUT = access_phase && st_r.slverr;
  assign RESULT_OUT = st_r.result;

  always_comb
  begin
    MUX_OUT.step_en = st_r.step_en; // [RULE5]
    MUX_OUT.gain_onehot = gain_onehot(st_r.gain); // [RULE6]
    MUX_OUT.pos_code = st_r.pos_sel;
    MUX_OUT.ext_onehot = 8'h00;
    MUX_OUT.int_onehot = 8'h00;
    MUX_OUT.neg_gnd = 1'b0;
    MUX_OUT.neg_ext7 = 1'b0;
    MUX_OUT.neg_auto = 1'b0;
    if (st_r.pos_sel[3])
    begin
      // Internal sources: index 0 temp, 1 short, 2 test, 3..7 supply monitors
      MUX_OUT.int_onehot = 8'h01 << st_r.pos_sel[2:0]; // [RULE10] [RULE11]
      MUX_OUT.neg_auto = 1'b1; // [RULE9]
    end
    else
    begin
      MUX_OUT.ext_onehot = 8'h01 << st_r.pos_sel[2:0]; // [RULE8]
      MUX_OUT.neg_ext7 = st_r.neg_sel; // [RULE7]
      MUX_OUT.neg_gnd = !st_r.neg_sel; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  sequence s_step_read_setup;
    setup_phase && !PWRITE_IN && (PADDR_IN == aac_pkg::ADDR_STEP0_CFG);
  endsequence

  sequence s_full_write(logic [11:0] a);
    access_phase && PWRITE_IN && (PADDR_IN == a) && (PSTRB_IN[1:0] == 2'h3);
  endsequence

  a_rsvd_read_zero: assert property (s_step_read_setup |=> // [RULE12]
    (PRDATA_OUT[12:5] == 8'h00) && (PRDATA_OUT[31:16] == 16'h0000))
    else $error("Reserved step bits read non-zero");

  a_offset_write_hold: assert property (s_full_write(aac_pkg::ADDR_OFFSET_CORR) |=> // [RULE1]
    (st_r.ocal == $past(PWDATA_IN[15:0])))
    else $error("Offset word not written");

  a_step_enable_out: assert property (s_full_write(aac_pkg::ADDR_STEP0_CFG) |=> // [RULE5]
    (MUX_OUT.step_en == $past(PWDATA_IN[15])) && (MUX_OUT.pos_code == $past(PWDATA_IN[3:0])))
    else $error("Step enable not following write");

  a_gain_four_map: assert property (st_r.gain[1] |-> MUX_OUT.gain_onehot == 3'h4) // [RULE6]
    else $error("Gain codes 10 and 11 must give four");

  a_neg_auto_pick: assert property (st_r.pos_sel[3] |-> // [RULE9]
    MUX_OUT.neg_auto && !MUX_OUT.neg_ext7 && !MUX_OUT.neg_gnd)
    else $error("Negative select not automatic for internal source");

  a_neg_ext_pick: assert property (!st_r.pos_sel[3] && st_r.neg_sel |-> // [RULE7]
    MUX_OUT.neg_ext7 && !MUX_OUT.neg_gnd && !MUX_OUT.neg_auto)
    else $error("Negative external input not selected");

  a_pos_ext_pick: assert property (!st_r.pos_sel[3] |-> // [RULE8]
    (MUX_OUT.ext_onehot == (8'h01 << st_r.pos_sel[2:0])) && (MUX_OUT.int_onehot == 8'h00))
    else $error("External positive input wrong");

  a_temp_short_map: assert property ((st_r.pos_sel == aac_pkg::POS_TEMP_SENSOR) || // [RULE10]
    (st_r.pos_sel == aac_pkg::POS_INT_SHORT) |->
    (MUX_OUT.int_onehot == {6'h00, st_r.pos_sel[0], !st_r.pos_sel[0]}))
    else $error("Temperature or short route wrong");

  a_supply_route: assert property (st_r.pos_sel == 4'hf |-> // [RULE11]
    (MUX_OUT.int_onehot == 8'h80) && (MUX_OUT.ext_onehot == 8'h00))
    else $error("Supply monitor route wrong");

  a_unity_offset: assert property (SAMPLE_IN.valid && (st_r.gain == 2'h0) && // [RULE2]
    (st_r.gcal == 16'h0000) |=> RESULT_OUT.valid && (RESULT_OUT.clip ||
    (RESULT_OUT.data == $past(SAMPLE_IN.data) + $past(st_r.ocal))))
    else $error("Unity gain offset not one step");

  a_half_offset: assert property (SAMPLE_IN.valid && (st_r.gain != 2'h0) && // [RULE3]
    (st_r.gcal == 16'h0000) && (st_r.ocal == 16'h0002) && (SAMPLE_IN.data == 16'sh0100) |=>
    RESULT_OUT.valid && (RESULT_OUT.data == 16'sh0101))
    else $error("High gain offset not half step");

  a_gain_half_factor: assert property (SAMPLE_IN.valid && (st_r.gcal == 16'h8000) && // [RULE4]
    (st_r.ocal == 16'h0000) |=> RESULT_OUT.valid && !RESULT_OUT.clip &&
    (RESULT_OUT.data == ($past(SAMPLE_IN.data) >>> 1)))
    else $error("Most negative gain code not one half");

  sequence s_unmapped_setup;
    setup_phase && !addr_hit;
  endsequence

  sequence s_offset_read_setup;
    setup_phase && !PWRITE_IN && (PADDR_IN == aac_pkg::ADDR_OFFSET_CORR);
  endsequence

  a_unmapped_error: assert property (s_unmapped_setup ##1 access_phase |->
    PSLVERR_OUT && PREADY_OUT)
    else $error("Unmapped access without error response");

  a_unmapped_write_keep: assert property (access_phase && PWRITE_IN && !addr_hit |=>
    $stable(st_r.ocal) && $stable(st_r.gcal) && $stable(step_word))
    else $error("Write to unmapped place changed a register");

  a_offset_read_data: assert property (s_offset_read_setup |=> // [RULE1]
    (PRDATA_OUT == {16'h0000, $past(st_r.ocal)}))
    else $error("Offset word read data wrong");

  a_gain_write_hold: assert property (s_full_write(aac_pkg::ADDR_GAIN_CORR) |=> // [RULE4]
    (st_r.gcal == $past(PWDATA_IN[15:0])))
    else $error("Gain word not written");

  a_low_lane_write: assert property (access_phase && PWRITE_IN && // [RULE1]
    (PADDR_IN == aac_pkg::ADDR_OFFSET_CORR) && (PSTRB_IN[1:0] == 2'h1) |=>
    (st_r.ocal[7:0] == $past(PWDATA_IN[7:0])) && $stable(st_r.ocal[15:8]))
    else $error("Low lane write to offset word wrong");

  a_result_latency: assert property (SAMPLE_IN.valid |=> RESULT_OUT.valid) // [RULE1]
    else $error("Corrected result not one cycle after sample");

  a_result_pulse: assert property (!SAMPLE_IN.valid |=> !RESULT_OUT.valid) // [RULE1]
    else $error("Corrected result valid without sample");

  a_gain_two_map: assert property (st_r.gain == aac_pkg::GAIN_CODE_X2 |-> // [RULE6]
    MUX_OUT.gain_onehot == 3'h2)
    else $error("Gain code 01 must give two");

  a_neg_gnd_pick: assert property (!st_r.pos_sel[3] && !st_r.neg_sel |-> // [RULE7]
    MUX_OUT.neg_gnd && !MUX_OUT.neg_ext7 && !MUX_OUT.neg_auto)
    else $error("Negative input not analog ground");

  a_test_route: assert property (st_r.pos_sel == 4'ha |-> // [RULE11]
    (MUX_OUT.int_onehot == 8'h04) && (MUX_OUT.ext_onehot == 8'h00))
    else $error("Test output route wrong");

  // Reset itself is watched, so the default disable is switched off here
  a_reset_clear: assert property (disable iff (1'b0) SRST_IN |=> // [RULE5]
    (step_word == aac_pkg::RST_STEP0_CFG) && (st_r.ocal == aac_pkg::RST_OFFSET_CORR) &&
    (st_r.gcal == aac_pkg::RST_GAIN_CORR) && !RESULT_OUT.valid)
    else $error("Registers not cleared by reset");

endmodule : aac_regs
